// >>> verilog/sfr_requester.sv
// core-side requester: page pointers, extension and event transfers
module sfr_requester
  import sfr_access_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // link to the access unit
  sfr_bus_if.host                bus,
  // page pointer load
  input  wire logic              ppWe,
  input  wire logic [1:0]        ppSel,
  input  wire logic [PAGE_W-1:0] ppPage,
  // register extension: count holds accesses minus one
  input  wire logic              extStart,
  input  wire logic [1:0]        extCount,
  // processor command
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire logic              cmdShort,
  input  wire logic [15:0]       cmdAddr,
  input  wire logic              cmdWrite,
  input  wire logic              cmdByte,
  input  wire logic [15:0]       cmdData,
  // event transfer command
  input  wire logic              pecStart,
  input  wire logic [15:0]       pecSrc,
  input  wire logic [15:0]       pecDst,
  input  wire logic              pecByte,
  output logic                   pecBusy,
  // result
  output logic                   resValid,
  output logic [15:0]            resData,
  output logic                   resErr
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_CPU, S_CPU_WAIT, S_RD, S_RD_WAIT, S_WR, S_WR_WAIT
  } req_state_type;

  req_state_type     state_ff, nxt_state;
  logic [PAGE_W-1:0] page_pointer_set [0:3];
  logic [2:0]        extLeft_ff;
  access_kind_type   kind_ff;
  logic [15:0]       addr_ff, data_ff, dst_ff;
  logic              write_ff, byte_ff, ext_ff;
  logic [PAGE_W-1:0] page_ff;
  logic              resValid_ff, resErr_ff;
  logic [15:0]       resData_ff;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------

  // the transfer controller preempts the processor command
  assign cmdReady = (state_ff == S_IDLE) && !pecStart;
  assign pecBusy  = (state_ff == S_RD) || (state_ff == S_RD_WAIT) ||
                    (state_ff == S_WR) || (state_ff == S_WR_WAIT);

  wire logic cmdTake = cmdValid && cmdReady;
  wire logic [PAGE_W-1:0] selPage = page_pointer_set[cmdAddr[15:14]];
  // a full address is only issued once its pointer names page 3
  wire logic pageBad = !cmdShort && (selPage != SFR_PAGE); // [RQ8]
  wire logic taken   = bus.req && bus.ready;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:     if (pecStart) begin
                    nxt_state = S_RD;
                  end else if (cmdTake && !pageBad) begin
                    nxt_state = S_CPU;
                  end
      S_CPU:      if (taken) nxt_state = S_CPU_WAIT;
      S_CPU_WAIT: if (bus.rvalid) nxt_state = S_IDLE;
      S_RD:       if (taken) nxt_state = S_RD_WAIT;
      S_RD_WAIT:  if (bus.rvalid) begin
                    nxt_state = bus.err ? S_IDLE : S_WR;
                  end
      S_WR:       if (taken) nxt_state = S_WR_WAIT;
      S_WR_WAIT:  if (bus.rvalid) nxt_state = S_IDLE;
      default:    nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // page pointers and extension window
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        page_pointer_set[i] <= SFR_PAGE;
      end
    end else if (ppWe) begin
      page_pointer_set[ppSel] <= ppPage;
    end
  end

  // each accepted short access uses up one extended access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      extLeft_ff <= EXT_ZERO;
    end else if (extStart) begin
      extLeft_ff <= {1'b0, extCount} + EXT_ONE; // [RQ7]
    end else if (taken && kind_ff == ACC_SHORT &&
                 extLeft_ff != EXT_ZERO) begin
      extLeft_ff <= extLeft_ff - EXT_ONE; // [RQ7]
    end
  end

  // ---------------------------------------------------------------
  // request fields
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      kind_ff <= ACC_MEM;
      addr_ff <= '0;
      data_ff <= '0;
      dst_ff  <= '0;
      write_ff <= 1'b0;
      byte_ff  <= 1'b0;
      ext_ff   <= 1'b0;
      page_ff  <= SFR_PAGE;
    end else if (state_ff == S_IDLE && pecStart) begin
      kind_ff  <= ACC_PEC_XFER; // own pointers, no page pointer [RQ9]
      addr_ff  <= pecSrc; // [RQ9]
      dst_ff   <= pecDst;
      write_ff <= 1'b0;
      byte_ff  <= pecByte;
    end else if (cmdTake) begin
      kind_ff  <= cmdShort ? ACC_SHORT : ACC_MEM;
      addr_ff  <= cmdAddr;
      data_ff  <= cmdData & IMPL_MASK; // reserved bits zero [RQ11]
      write_ff <= cmdWrite;
      byte_ff  <= cmdByte;
      ext_ff   <= cmdShort && (extLeft_ff != EXT_ZERO); // [RQ7]
      page_ff  <= selPage;
    end else if (state_ff == S_RD_WAIT && bus.rvalid) begin
      addr_ff  <= dst_ff; // [RQ9]
      data_ff  <= bus.rdata;
      write_ff <= 1'b1;
    end
  end

  assign bus.req    = (state_ff == S_CPU) || (state_ff == S_RD) ||
                      (state_ff == S_WR);
  assign bus.kind   = kind_ff;
  assign bus.ext    = ext_ff;
  assign bus.page   = page_ff;
  assign bus.addr   = addr_ff;
  assign bus.write  = write_ff;
  assign bus.byteOp = byte_ff;
  assign bus.wdata  = data_ff;

  // ---------------------------------------------------------------
  // result
  // ---------------------------------------------------------------

  // a bad page pointer answers at once without touching the link
  wire logic doneNow = bus.rvalid && (state_ff == S_CPU_WAIT ||
                       state_ff == S_WR_WAIT ||
                       (state_ff == S_RD_WAIT && bus.err));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      resValid_ff <= 1'b0;
      resErr_ff   <= 1'b0;
      resData_ff  <= '0;
    end else begin
      resValid_ff <= doneNow || (cmdTake && pageBad); // [RQ8]
      resErr_ff   <= doneNow ? bus.err : (cmdTake && pageBad);
      if (doneNow) begin
        resData_ff <= bus.rdata;
      end else if (cmdTake && pageBad) begin
        resData_ff <= '0;
      end
    end
  end

  assign resValid = resValid_ff;
  assign resErr   = resErr_ff;
  assign resData  = resData_ff;

endmodule

// >>> verilog/sfr_access_pkg.sv
// shared constants and types of the peripheral register access path
package sfr_access_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [15:0] STD_BASE   = 16'hFE00; // standard region
  localparam logic [15:0] EXT_BASE   = 16'hF000; // extended region
  localparam int          REGION_LSB = 9;        // 512-byte regions
  localparam int          PAGE_W     = 10;
  localparam logic [PAGE_W-1:0] SFR_PAGE = 10'h003;
  localparam int          IDX_W      = 9;        // region bit + word
  localparam int          WORDS      = 512;      // both regions

  // ---------------------------------------------------------------
  // register contents
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] IMPL_MASK = 16'h3FFF; // bits 15:14 reserved
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          STATE_CLKS = 2;       // core_clk per state
  localparam logic [0:0]  STATE_LAST = 1'h1;    // STATE_CLKS - 1
  localparam logic [1:0]  EXT_NONE   = 2'h0;
  localparam logic [2:0]  EXT_ZERO   = 3'h0;
  localparam logic [2:0]  EXT_ONE    = 3'h1;

  // ---------------------------------------------------------------
  // access kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_MEM,
    ACC_SHORT,
    ACC_PEC_XFER
  } access_kind_type;

endpackage

// >>> verilog/sfr_bus_if.sv
// link between the requesting core side and the register access unit
interface sfr_bus_if;
  import sfr_access_pkg::*;

  // request from the core or event transfer controller
  logic                  req;
  access_kind_type       kind;
  logic                  ext;
  logic [PAGE_W-1:0]     page;
  logic [15:0]           addr;
  logic                  write;
  logic                  byteOp;
  logic [15:0]           wdata;
  // answer from the access unit
  logic                  ready;
  logic                  rvalid;
  logic [15:0]           rdata;
  logic                  err;

  modport dev (
    input  req, kind, ext, page, addr, write, byteOp, wdata,
    output ready, rvalid, rdata, err
  );

  modport host (
    output req, kind, ext, page, addr, write, byteOp, wdata,
    input  ready, rvalid, rdata, err
  );

endinterface

// >>> verilog/sfr_access_unit.sv
// peripheral register bank with core and event transfer access
// Notes on behaviour
// RQ1 - decode standard and extended 512-byte regions
// RQ2 - one processor access per machine state
// RQ3 - software write beats same-state peripheral update
// RQ4 - full-address or transfer byte write zeroes other
// RQ5 - short byte write hits low byte, clears high
// RQ6 - short addresses map straight to standard region
// RQ7 - extension redirects short addresses to extended region
// RQ8 - full addresses need page pointer on page 3
// RQ9 - transfers use own source/destination pointers
// RQ10 - reserved bits read back as zero
// RQ11 - software writes zeros into reserved bits
// RQ12 - idle stops processor, peripherals keep running
// RQ13 - peripherals signal completion and error events
module sfr_access_unit
  import sfr_access_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // requester link
  sfr_bus_if.dev                bus,
  // power mode
  input  wire logic             idleMode,
  // peripheral hardware update port
  input  wire logic             periphWe,
  input  wire logic [IDX_W-1:0] periphIdx,
  input  wire logic [15:0]      periphData,
  // peripheral readback port
  input  wire logic [IDX_W-1:0] peekIdx,
  output logic      [15:0]      peekData,
  // event outputs
  output logic                  doneIrq,
  output logic                  faultIrq
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // returns {hit, index}; index msb selects the extended region
  function automatic logic [IDX_W:0] decodeAccess(
    input access_kind_type   kind,
    input logic              ext,
    input logic [PAGE_W-1:0] page,
    input logic [15:0]       addr
  );
    logic pageOk;
    pageOk = (kind == ACC_PEC_XFER) || (page == SFR_PAGE); // [RQ9]
    decodeAccess = '0;
    if (kind == ACC_SHORT) begin
      // no page pointer is consulted for short addresses
      decodeAccess = {1'b1, ext, addr[7:0]}; // [RQ6] [RQ7]
    end else if (pageOk &&
                 addr[15:REGION_LSB] == STD_BASE[15:REGION_LSB]) begin
      decodeAccess = {1'b1, 1'b0, addr[8:1]}; // [RQ1]
    end else if (pageOk &&
                 addr[15:REGION_LSB] == EXT_BASE[15:REGION_LSB]) begin
      decodeAccess = {1'b1, 1'b1, addr[8:1]}; // [RQ1]
    end
  endfunction

  // places a written byte into its lane and zeroes the other lane
  function automatic logic [15:0] placeByte(
    input logic       hiLane,
    input logic [7:0] value
  );
    placeByte = hiLane ? {value, ZERO_BYTE} : {ZERO_BYTE, value};
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0]      regs [0:WORDS-1];

  logic [0:0]       stateCnt_ff;
  logic             rvalid_ff;
  logic [15:0]      rdata_ff;
  logic             err_ff;
  logic             lastSwValid_ff;
  logic [IDX_W-1:0] lastSwIdx_ff;
  logic [15:0]      peek_ff;
  logic             doneIrq_ff;
  logic             faultIrq_ff;

  // ---------------------------------------------------------------
  // machine state timing
  // ---------------------------------------------------------------

  // a state is STATE_CLKS core clocks; stateEn marks its single
  // access slot so back-to-back requests cannot double up
  wire logic stateEn = (stateCnt_ff == '0); // [RQ2]

  always_ff @(posedge core_clk) begin
    if (reset || stateCnt_ff == STATE_LAST) begin
      stateCnt_ff <= '0;
    end else begin
      stateCnt_ff <= stateCnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // request acceptance and decode
  // ---------------------------------------------------------------

  // the processor clock is gone in idle; only event transfers and
  // peripheral updates still reach the registers
  wire logic kindAllowed =
    (bus.kind == ACC_PEC_XFER) || !idleMode; // [RQ12]
  wire logic take = bus.req && bus.ready;

  assign bus.ready = stateEn && kindAllowed; // [RQ2] [RQ12]

  wire logic [IDX_W:0]   decoded =
    decodeAccess(bus.kind, bus.ext, bus.page, bus.addr);
  wire logic             hit     = decoded[IDX_W];
  wire logic [IDX_W-1:0] idx     = decoded[IDX_W-1:0];

  // short byte accesses only ever reach the low byte
  wire logic hiLane = (bus.kind != ACC_SHORT) && bus.addr[0]; // [RQ5]

  // ---------------------------------------------------------------
  // write data shaping
  // ---------------------------------------------------------------

  // a byte write never preserves the other byte: it is zeroed for
  // full-address, transfer and short writes alike
  wire logic [15:0] byteVal = placeByte(hiLane, bus.wdata[7:0]);
  wire logic [15:0] rawVal  =
    bus.byteOp ? byteVal : bus.wdata; // [RQ4] [RQ5]
  // reserved positions are never stored, so they read zero
  wire logic [15:0] swVal   = rawVal & IMPL_MASK; // [RQ10]
  wire logic        swWr    = take && hit && bus.write;

  // a peripheral update loses against a software write that lands
  // on the same register anywhere inside the same state
  wire logic swSameNow  = swWr && (idx == periphIdx);
  wire logic swSameLast = lastSwValid_ff && !stateEn &&
                          (lastSwIdx_ff == periphIdx);
  wire logic hwWr       =
    periphWe && !swSameNow && !swSameLast; // [RQ3]

  // ---------------------------------------------------------------
  // read data shaping
  // ---------------------------------------------------------------
  wire logic [15:0] wordRd = regs[idx] & IMPL_MASK; // [RQ10]
  wire logic [15:0] byteRd =
    {ZERO_BYTE, hiLane ? wordRd[15:8] : wordRd[7:0]};
  wire logic [15:0] rdVal  = bus.byteOp ? byteRd : wordRd;

  // ---------------------------------------------------------------
  // register array
  // ---------------------------------------------------------------

  // peripherals keep writing in idle: nothing here looks at idleMode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else begin
      if (hwWr) begin
        regs[periphIdx] <= periphData & IMPL_MASK; // [RQ12]
      end
      if (swWr) begin
        regs[idx] <= swVal; // [RQ3]
      end
    end
  end

  // remember the software write target until the state ends
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lastSwValid_ff <= 1'b0;
      lastSwIdx_ff   <= '0;
    end else if (stateEn) begin
      lastSwValid_ff <= swWr;
      lastSwIdx_ff   <= idx;
    end
  end

  // ---------------------------------------------------------------
  // answer to the requester
  // ---------------------------------------------------------------

  // answers arrive one cycle after acceptance; an unmapped address
  // answers with err and zero data rather than hanging the core
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= REG_RESET;
      err_ff    <= 1'b0;
    end else begin
      rvalid_ff <= take;
      err_ff    <= take && !hit;
      if (take) begin
        rdata_ff <= (hit && !bus.write) ? rdVal : REG_RESET;
      end
    end
  end

  assign bus.rvalid = rvalid_ff;
  assign bus.rdata  = rdata_ff;
  assign bus.err    = err_ff;

  // ---------------------------------------------------------------
  // peripheral readback and events
  // ---------------------------------------------------------------

  // one-cycle event pulses: completed write and refused address
  always_ff @(posedge core_clk) begin
    if (reset) begin
      peek_ff     <= REG_RESET;
      doneIrq_ff  <= 1'b0;
      faultIrq_ff <= 1'b0;
    end else begin
      peek_ff     <= regs[peekIdx] & IMPL_MASK;
      doneIrq_ff  <= swWr; // [RQ13]
      faultIrq_ff <= take && !hit; // [RQ13]
    end
  end

  assign peekData = peek_ff;
  assign doneIrq  = doneIrq_ff;
  assign faultIrq = faultIrq_ff;

endmodule

// >>> test/sfr_access_asserts.sv
// link checker for the register access path
module sfr_access_asserts
  import sfr_access_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // link signals
  input wire logic              req,
  input wire access_kind_type   kind,
  input wire logic [PAGE_W-1:0] page,
  input wire logic [15:0]       addr,
  input wire logic              ready,
  input wire logic              rvalid,
  input wire logic [15:0]       rdata,
  input wire logic              err
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // a taken request and whether its address lies in either region
  wire logic take  = req && ready;
  wire logic hit   = (addr[15:9] == STD_BASE[15:9]) ||
                     (addr[15:9] == EXT_BASE[15:9]);
  wire logic memOk = (kind == ACC_MEM) && (page == SFR_PAGE);

  // ---------------------------------------------------------------
  // link timing and decode
  // ---------------------------------------------------------------
  AST_ANSWER: assert property (take |=> rvalid)
    else $error("no answer one cycle after a taken request");
  AST_NO_STRAY: assert property (!take |=> !rvalid)
    else $error("answer without a taken request");
  AST_ONE_PER_STATE: assert property (take |=> !ready)
    else $error("second acceptance inside one state");
  AST_HOLD: assert property (req && !ready |=>
    req && $stable(addr) && $stable(kind))
    else $error("request dropped or changed while waiting");
  AST_ERR_PAIR: assert property (err |-> rvalid)
    else $error("error flag without answer");
  AST_RSVD_ZERO: assert property (rvalid |-> rdata[15:14] == 2'b00)
    else $error("reserved bits read back nonzero");
  AST_UNMAPPED: assert property (take && memOk && !hit |=> err)
    else $error("unmapped full address not refused");
  AST_MAPPED: assert property (take && memOk && hit |=> !err)
    else $error("mapped full address refused");
  AST_SHORT: assert property (take && kind == ACC_SHORT |=> !err)
    else $error("short address refused");
  AST_PEC_FREE: assert property (take && kind == ACC_PEC_XFER && hit
    |=> !err)
    else $error("transfer access refused on a mapped address");
endmodule

// >>> test/test_peripheral_sfr_access.sv
// self-checking bench for both ends of the register access link
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); \
  end \
end

module test_peripheral_sfr_access
  import sfr_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // stimulus and observation signals
  // ---------------------------------------------------------------
  typedef struct {
    logic sh; logic wr; logic by; logic [15:0] a; logic [15:0] d;
    logic [15:0] expD; logic expE;
  } row_type;
  logic              core_clk = 0, reset = 1, idleMode = 0, periphWe = 0;
  logic [IDX_W-1:0]  periphIdx = '0, peekIdx = 9'h004;
  logic [15:0]       periphData = '0, cmdAddr = '0, cmdData = '0;
  logic              ppWe = 0, extStart = 0, cmdValid = 0, cmdShort = 0;
  logic              cmdWrite = 0, cmdByte = 0, pecStart = 0, pecByte = 0;
  logic [1:0]        ppSel = 2'h3, extCount = 2'h0;
  logic [PAGE_W-1:0] ppPage = SFR_PAGE;
  logic [15:0]       pecSrc = '0, pecDst = '0, gotD, resData, peekData;
  logic              gotE, seen, cmdReady, pecBusy, resValid, resErr;
  logic              doneIrq, faultIrq;
  int                fails = 0, num_checks = 0, faultCnt = 0, doneCnt = 0;
  // plain cpu accesses; later rows read what earlier rows wrote
  row_type rows [14] = '{
    '{0, 1, 0, 16'hFE04, 16'hFFFF, 16'h0000, 0},
    '{0, 0, 0, 16'hFE04, 16'h0000, 16'h3FFF, 0},
    '{0, 1, 1, 16'hFE05, 16'h0012, 16'h0000, 0},
    '{0, 0, 0, 16'hFE04, 16'h0000, 16'h1200, 0},
    '{1, 1, 1, 16'h0002, 16'h0034, 16'h0000, 0},
    '{0, 0, 0, 16'hFE04, 16'h0000, 16'h0034, 0},
    '{1, 0, 0, 16'h0002, 16'h0000, 16'h0034, 0},
    '{0, 1, 0, 16'hFA00, 16'h0001, 16'h0000, 1},
    '{0, 0, 0, 16'hFA00, 16'h0000, 16'h0000, 1},
    '{0, 1, 0, 16'hF1FE, 16'h2222, 16'h0000, 0},
    '{0, 0, 0, 16'hF1FE, 16'h0000, 16'h2222, 0},
    '{0, 0, 0, 16'hF200, 16'h0000, 16'h0000, 1},
    '{0, 1, 0, 16'hFE08, 16'h1234, 16'h0000, 0},
    '{0, 0, 0, 16'hFFFE, 16'h0000, 16'h0000, 0}
  };

  // ---------------------------------------------------------------
  // both ends joined by the link, checker beside it
  // ---------------------------------------------------------------
  sfr_bus_if sfr_bus_if_i ();
  sfr_access_unit sfr_access_unit_i (.core_clk, .reset, .bus(sfr_bus_if_i),
    .idleMode, .periphWe, .periphIdx, .periphData, .peekIdx, .peekData,
    .doneIrq, .faultIrq);
  sfr_requester sfr_requester_i (.core_clk, .reset, .bus(sfr_bus_if_i),
    .ppWe, .ppSel, .ppPage, .extStart, .extCount, .cmdValid, .cmdReady,
    .cmdShort, .cmdAddr, .cmdWrite, .cmdByte, .cmdData, .pecStart, .pecSrc,
    .pecDst, .pecByte, .pecBusy, .resValid, .resData, .resErr);
  sfr_access_asserts sfr_access_asserts_i (.core_clk, .reset,
    .req(sfr_bus_if_i.req), .kind(sfr_bus_if_i.kind),
    .page(sfr_bus_if_i.page), .addr(sfr_bus_if_i.addr),
    .ready(sfr_bus_if_i.ready), .rvalid(sfr_bus_if_i.rvalid),
    .rdata(sfr_bus_if_i.rdata), .err(sfr_bus_if_i.err));

  // ---------------------------------------------------------------
  // clock, event count and closing
  // ---------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  // sampled mid-cycle so the registered pulse has settled
  always @(negedge core_clk) if (faultIrq === 1'b1) faultCnt++;
  always @(negedge core_clk) if (doneIrq === 1'b1) doneCnt++;

  task automatic wrap_up;
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // result wait is bounded so a lost answer cannot hang the run
  task automatic await_res;
    seen = 0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge core_clk);
      if (resValid === 1'b1) begin
        seen = 1;
        gotD = resData;
        gotE = resErr;
      end
    end
    `CHK("resValid", 1'b1, seen)
  endtask

  task automatic cmd(input logic s, w, b, input logic [15:0] a, d);
    @(posedge core_clk);
    cmdValid <= 1;
    cmdShort <= s;
    cmdWrite <= w;
    cmdByte  <= b;
    cmdAddr  <= a;
    cmdData  <= d;
    @(negedge core_clk);
    for (int i = 0; i < 60 && cmdReady !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    cmdValid <= 0;
    await_res;
  endtask

  task automatic event_transfer_controller(input logic b, input logic [15:0] s, t);
    @(posedge core_clk);
    pecStart <= 1;
    pecByte  <= b;
    pecSrc   <= s;
    pecDst   <= t;
    @(posedge core_clk);
    pecStart <= 0;
    @(negedge core_clk);
    `CHK("pecBusy", 1'b1, pecBusy)
    await_res;
  endtask

  task automatic pp(input logic [PAGE_W-1:0] p);
    @(posedge core_clk);
    ppWe   <= 1;
    ppPage <= p;
    @(posedge core_clk);
    ppWe   <= 0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 0;
    repeat (2) @(negedge core_clk);
    `CHK("peekData", 16'h0000, peekData)
    foreach (rows[k]) begin
      cmd(rows[k].sh, rows[k].wr, rows[k].by, rows[k].a, rows[k].d);
      `CHK("row resData", rows[k].expD, gotD)
      `CHK("row resErr", rows[k].expE, gotE)
    end
    `CHK("faultCnt", 3, faultCnt)
    `CHK("doneCnt", 5, doneCnt)
    // idle: cpu waits while the peripheral side keeps updating
    @(posedge core_clk);
    idleMode   <= 1;
    periphWe   <= 1;
    periphIdx  <= 9'h005;
    periphData <= 16'hC123;
    peekIdx    <= 9'h005;
    fork
      cmd(0, 0, 0, 16'hFE0A, 16'h0000);
      begin
        repeat (12) @(negedge core_clk);
        `CHK("idle peekData", 16'h0123, peekData)
        `CHK("idle resValid", 1'b0, seen)
        @(posedge core_clk);
        idleMode <= 0;
        periphWe <= 0;
      end
    join
    `CHK("idle resData", 16'h0123, gotD)
    // collision: update held across the taking state must lose
    @(posedge core_clk);
    periphWe   <= 1;
    periphIdx  <= 9'h003;
    periphData <= 16'h0AAA;
    peekIdx    <= 9'h003;
    fork
      cmd(0, 1, 0, 16'hFE06, 16'h0555);
      begin
        for (int i = 0; i < 60 && sfr_bus_if_i.rvalid !== 1'b1; i++)
          @(negedge core_clk);
        @(posedge core_clk);
        periphWe <= 0;
      end
    join
    repeat (3) @(negedge core_clk);
    `CHK("collision", 16'h0555, peekData)
    // extension window of one short access
    @(posedge core_clk);
    extStart <= 1;
    @(posedge core_clk);
    extStart <= 0;
    cmd(1, 1, 0, 16'h0001, 16'h0777);
    cmd(1, 0, 0, 16'h0001, 16'h0000);
    `CHK("window spent", 16'h0000, gotD)
    cmd(0, 0, 0, 16'hF002, 16'h0000);
    `CHK("ext word", 16'h0777, gotD)
    // wrong page refuses cpu access but not transfers
    pp(10'h005);
    cmd(0, 0, 0, 16'hFE04, 16'h0000);
    `CHK("page err", 1'b1, gotE)
    event_transfer_controller(0, 16'hFE08, 16'hF008);
    `CHK("pec err", 1'b0, gotE)
    event_transfer_controller(1, 16'hFE09, 16'hF007);
    pp(SFR_PAGE);
    cmd(0, 0, 0, 16'hF008, 16'h0000);
    `CHK("pec word", 16'h1234, gotD)
    cmd(0, 0, 0, 16'hF006, 16'h0000);
    `CHK("pec byte", 16'h1200, gotD)
    // second reset clears the bank
    @(posedge core_clk);
    reset <= 1;
    repeat (3) @(posedge core_clk);
    reset <= 0;
    cmd(0, 0, 0, 16'hFE08, 16'h0000);
    `CHK("after reset", 16'h0000, gotD)
    wrap_up;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    wrap_up;
  end
endmodule
